// [verilog/bdu_top.sv]
/*
  breakpoint debug unit: four comparators, status and control, guarded
  core access to the debug registers, apb slave and interrupt.
  assumes core strobes are one-cycle pulses on core_clk and apb on the
  same clock; the core raises at most one debug register request at once.
  status flags are cleared by writing zero; a written one leaves them be.
  an interrupt status read clears only the bits that it returned.
  the guard bit blocks the core port only; apb stays open for a debugger.
  reserved kind or width codes never match a data access.
*/
`timescale 1ns/10ps
`default_nettype none
`include "bdu_regs.svh"

module bdu_top (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic fetch_valid,
  input wire logic [31:0] fetch_addr,
  input wire logic data_valid,
  input wire logic [31:0] data_addr,
  input wire logic data_write,
  input wire logic [1:0] data_size,
  input wire logic step_done,
  input wire logic task_switch,
  input wire logic task_trap_bit,
  input wire logic dreg_req,
  input wire logic dreg_write,
  input wire logic [2:0] dreg_idx,
  input wire logic [31:0] dreg_wdata,
  output logic [31:0] dreg_rdata,
  output logic dreg_ack,
  output logic dreg_blocked,
  output logic debug_trap,
  output logic [7:0] trap_vector,
  output logic irq
);
  import bdu_pkg::*;

  bdu_state_t state_ff;
  bdu_state_t nxt_state;
  logic [3:0] match;
  logic [3:0] armed;
  logic [3:0] apb_map;
  logic apb_acc;
  logic apb_done;
  logic hit_armed;
  logic guard_evt;
  logic step_evt;
  logic task_evt;

  // ==========================================================
  // register read, shared by apb and core port
  function automatic logic [31:0] read_dreg(
    input bdu_state_t s,
    input logic [2:0] idx
  );
    logic [31:0] w;
    w = `BDU_WORD_RST;
    case (idx)
      3'h0, 3'h1, 3'h2, 3'h3: w = s.bp_addr[idx[1:0]];
      `BDU_IDX_STATUS: begin
        w[3:0] = s.hit;
        w[`BDU_ST_BD] = s.bd;
        w[`BDU_ST_BS] = s.bs;
        w[`BDU_ST_BT] = s.bt;
      end
      `BDU_IDX_CTRL: begin
        for (int i = 0; i < 4; i++) begin
          w[`BDU_CTRL_L(i)] = s.arm_l[i];
          w[`BDU_CTRL_G(i)] = s.arm_g[i];
          w[`BDU_CTRL_KIND(i) +: 2] = s.kind[i];
          w[`BDU_CTRL_LEN(i) +: 2] = s.width[i];
        end
        w[`BDU_CTRL_LE] = s.le;
        w[`BDU_CTRL_GE] = s.ge;
        w[`BDU_CTRL_GD] = s.gd;
      end
      default: w = `BDU_WORD_RST;
    endcase
    return w;
  endfunction

  // ==========================================================
  // register write, shared by apb and core port
  function automatic bdu_state_t write_dreg(
    input bdu_state_t s,
    input logic [2:0] idx,
    input logic [31:0] w
  );
    bdu_state_t r;
    r = s;
    case (idx)
      3'h0, 3'h1, 3'h2, 3'h3: r.bp_addr[idx[1:0]] = w;
      `BDU_IDX_STATUS: begin
        // software can only clear a flag; a written one keeps it as is
        r.hit = s.hit & w[3:0]; // [RULE3]
        r.bd = s.bd & w[`BDU_ST_BD]; // [RULE3]
        r.bs = s.bs & w[`BDU_ST_BS]; // [RULE3]
        r.bt = s.bt & w[`BDU_ST_BT]; // [RULE3]
      end
      `BDU_IDX_CTRL: begin
        for (int i = 0; i < 4; i++) begin
          r.arm_l[i] = w[`BDU_CTRL_L(i)];
          r.arm_g[i] = w[`BDU_CTRL_G(i)];
          r.kind[i] = w[`BDU_CTRL_KIND(i) +: 2];
          r.width[i] = w[`BDU_CTRL_LEN(i) +: 2];
        end
        // le and ge kept for read-back only; gd is the guard bit
        r.le = w[`BDU_CTRL_LE]; // [RULE13]
        r.ge = w[`BDU_CTRL_GE]; // [RULE13]
        r.gd = w[`BDU_CTRL_GD];
      end
      default: r = s;
    endcase
    return r;
  endfunction

  // ==========================================================
  // apb address to {mapped, index} of a debug register
  function automatic logic [3:0] apb_dreg(input logic [7:0] a);
    logic [3:0] m;
    m = 4'h0;
    case (a)
      `BDU_ADDR_BP0: m = 4'h8;
      `BDU_ADDR_BP1: m = 4'h9;
      `BDU_ADDR_BP2: m = 4'hA;
      `BDU_ADDR_BP3: m = 4'hB;
      `BDU_ADDR_STATUS: m = {1'b1, `BDU_IDX_STATUS};
      `BDU_ADDR_CTRL: m = {1'b1, `BDU_IDX_CTRL};
      default: m = 4'h0;
    endcase
    return m;
  endfunction

  // ==========================================================
  // apb read data and error of one address
  function automatic logic [32:0] apb_read(
    input bdu_state_t s,
    input logic [7:0] a
  );
    logic [3:0] m;
    logic [32:0] v;
    m = apb_dreg(a);
    v = {1'b0, `BDU_WORD_RST};
    if (m[3]) begin
      v[31:0] = read_dreg(s, m[2:0]);
    end else if (a == `BDU_ADDR_IRQ_STS) begin
      v[3:0] = s.irq_sts;
    end else if (a == `BDU_ADDR_IRQ_MASK) begin
      v[3:0] = s.irq_mask;
    end else begin
      // unmapped: error with zero data, a write is dropped
      v[32] = 1'b1;
    end
    return v;
  endfunction

  // ==========================================================
  // interrupt status bits raised in one cycle
  function automatic logic [3:0] irq_events(
    input logic hit_ev,
    input logic guard_ev,
    input logic step_ev,
    input logic task_ev
  );
    logic [3:0] v;
    v = '0;
    v[`BDU_IRQ_HIT] = hit_ev;
    v[`BDU_IRQ_GUARD] = guard_ev;
    v[`BDU_IRQ_STEP] = step_ev;
    v[`BDU_IRQ_TASK] = task_ev;
    return v;
  endfunction

  // ==========================================================
  // reset image: every register cleared, nothing armed or pending
  function automatic bdu_state_t rst_state();
    bdu_state_t r;
    for (int i = 0; i < 4; i++) begin
      r.bp_addr[i] = `BDU_WORD_RST;
      r.kind[i] = `BDU_KIND_EXEC;
      r.width[i] = `BDU_LEN_1;
    end
    r.hit = '0;
    r.bd = '0;
    r.bs = '0;
    r.bt = '0;
    r.arm_l = '0;
    r.arm_g = '0;
    r.le = '0;
    r.ge = '0;
    r.gd = '0;
    r.irq_sts = '0;
    r.irq_mask = '0;
    r.prdata = `BDU_WORD_RST;
    r.pready = '0;
    r.pslverr = '0;
    r.trap = '0;
    // the vector reads 0 in reset and is set from the first edge after it
    r.trap_vec = '0;
    r.irq = '0;
    r.dreg_rdata = `BDU_WORD_RST;
    r.dreg_ack = '0;
    r.dreg_blocked = '0;
    return r;
  endfunction

  // ==========================================================
  // comparators
  for (genvar g = 0; g < 4; g++) begin : g_cmp
    bdu_match u_match (
      .bp_addr(state_ff.bp_addr[g]),
      .width(state_ff.width[g]),
      .kind(state_ff.kind[g]),
      .fetch_valid(fetch_valid),
      .fetch_addr(fetch_addr),
      .data_valid(data_valid),
      .data_addr(data_addr),
      .data_write(data_write),
      .data_size(data_size),
      .match(match[g])
    ); // [RULE1]
  end

  // ==========================================================
  // trap causes
  always_comb begin
    armed = state_ff.arm_l | state_ff.arm_g; // [RULE11]
    hit_armed = |(match & armed); // [RULE11]
    guard_evt = dreg_req && state_ff.gd; // [RULE14]
    step_evt = step_done;
    task_evt = task_switch && task_trap_bit; // [RULE6]

    apb_map = apb_dreg(paddr);
    apb_acc = psel && penable;
    apb_done = apb_acc && state_ff.pready;
  end

  // ==========================================================
  // next state
  always_comb begin
    nxt_state = state_ff;
    nxt_state.trap = 1'b0;
    nxt_state.dreg_ack = 1'b0;
    nxt_state.dreg_blocked = 1'b0;
    nxt_state.trap_vec = `BDU_TRAP_VEC; // [RULE1]

    // apb: one wait state, answer registered so outputs come from flops
    if (apb_acc && !state_ff.pready) begin
      nxt_state.pready = 1'b1;
      {nxt_state.pslverr, nxt_state.prdata} = apb_read(state_ff, paddr);
    end else begin
      nxt_state.pready = 1'b0;
      nxt_state.pslverr = 1'b0;
      nxt_state.prdata = `BDU_WORD_RST;
    end

    // apb write or read side effect at the completing edge
    if (apb_done && pwrite && !state_ff.pslverr) begin
      if (apb_map[3]) begin
        nxt_state = write_dreg(nxt_state, apb_map[2:0], pwdata);
      end else if (paddr == `BDU_ADDR_IRQ_MASK) begin
        nxt_state.irq_mask = pwdata[3:0];
      end
    end
    if (apb_done && !pwrite && paddr == `BDU_ADDR_IRQ_STS) begin
      // only the bits that were read are cleared, so an event that lands
      // between the data phase and the completing edge is not lost
      nxt_state.irq_sts = state_ff.irq_sts & ~state_ff.prdata[3:0];
    end

    // core debug register port; a guarded request neither reads nor writes a register
    if (dreg_req) begin
      nxt_state.dreg_ack = 1'b1;
      nxt_state.dreg_rdata = `BDU_WORD_RST;
      if (state_ff.gd) begin
        nxt_state.dreg_blocked = 1'b1; // [RULE14]
      end else begin
        nxt_state.dreg_rdata = read_dreg(state_ff, dreg_idx);
        if (dreg_write) begin
          nxt_state = write_dreg(nxt_state, dreg_idx, dreg_wdata);
        end
      end
    end

    // hardware sets come last so they win over any clear
    nxt_state.hit = nxt_state.hit | match; // [RULE2] [RULE17] [RULE3]
    if (guard_evt) begin
      nxt_state.bd = 1'b1; // [RULE4] [RULE15]
      nxt_state.gd = 1'b0; // [RULE15]
    end
    if (step_evt) begin
      nxt_state.bs = 1'b1; // [RULE5]
    end
    if (task_evt) begin
      nxt_state.bt = 1'b1; // [RULE6]
    end
    if (task_switch) begin
      nxt_state.arm_l = 4'h0; // [RULE12]
    end

    // one trap pulse however many causes meet
    nxt_state.trap = hit_armed || guard_evt || step_evt || task_evt; // [RULE17]

    // sticky interrupt status, set wins over the read clear
    nxt_state.irq_sts = nxt_state.irq_sts |
      irq_events(hit_armed, guard_evt, step_evt, task_evt);
    nxt_state.irq = |(nxt_state.irq_sts & nxt_state.irq_mask);
  end

  // ==========================================================
  // state register
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      state_ff <= rst_state();
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ==========================================================
  // outputs straight from flops
  assign prdata = state_ff.prdata;
  assign pready = state_ff.pready;
  assign pslverr = state_ff.pslverr;
  assign dreg_rdata = state_ff.dreg_rdata;
  assign dreg_ack = state_ff.dreg_ack;
  assign dreg_blocked = state_ff.dreg_blocked;
  assign debug_trap = state_ff.trap;
  assign trap_vector = state_ff.trap_vec;
  assign irq = state_ff.irq;

endmodule // bdu_top
`default_nettype wire

// [pkg/bdu_regs.svh]
/*
  register map, field positions, codes and reset values of the breakpoint
  debug unit. assumes an includer that uses these names only as constants.
*/
// Functional notes
// [RULE1] four breakpoint addresses compared to core accesses; armed match raises trap vector 1
// [RULE2] hit flag n sets whenever comparator n matches, armed or not
// [RULE3] status flags set by hardware only; software clears them by writing zero
// [RULE4] trap from a guarded debug register access sets the guarded-access cause flag
// [RULE5] trap from the single-step request sets the single-step cause flag
// [RULE6] entering a task with trap-on-entry set raises a trap and sets task-entry flag
// [RULE7] width field: 00 one byte, 01 two bytes, 11 four bytes, 10 reserved
// [RULE8] software uses the one-byte width for instruction-execution breakpoints
// [RULE9] software aligns each breakpoint address to a multiple of its width
// [RULE10] kind field: 00 execution, 01 data write, 11 data read or write, 10 reserved
// [RULE11] a match traps only when its local or global arm bit is set
// [RULE12] every task switch clears the four local arm bits, global ones kept
// [RULE13] exact-match control bits are stored but have no effect
// [RULE14] with guard set, a core debug register access is not done and traps instead
// [RULE15] the guarded-access trap clears the guard bit and sets its cause flag
// [RULE16] data match when access touches any byte of the aligned breakpoint region
// [RULE17] several matches on one access set all hit flags and raise one trap
`ifndef BDU_REGS_SVH
`define BDU_REGS_SVH

// ==========================================================
// apb byte addresses
`define BDU_ADDR_BP0 8'h00
`define BDU_ADDR_BP1 8'h04
`define BDU_ADDR_BP2 8'h08
`define BDU_ADDR_BP3 8'h0C
`define BDU_ADDR_STATUS 8'h10
`define BDU_ADDR_CTRL 8'h14
`define BDU_ADDR_IRQ_STS 8'h18
`define BDU_ADDR_IRQ_MASK 8'h1C

// ==========================================================
// core-side debug register indices
`define BDU_IDX_STATUS 3'h6
`define BDU_IDX_CTRL 3'h7

// ==========================================================
// status fields
`define BDU_ST_BD 13
`define BDU_ST_BS 14
`define BDU_ST_BT 15

// ==========================================================
// control fields, per comparator n, then the single le, ge and gd bits
`define BDU_CTRL_L(n) (2*(n))
`define BDU_CTRL_G(n) (2*(n)+1)
`define BDU_CTRL_LE 8
`define BDU_CTRL_GE 9
`define BDU_CTRL_GD 13
`define BDU_CTRL_KIND(n) (16+4*(n))
`define BDU_CTRL_LEN(n) (18+4*(n))

// ==========================================================
// codes
`define BDU_KIND_EXEC 2'h0
`define BDU_KIND_WRITE 2'h1
`define BDU_KIND_RW 2'h3
`define BDU_LEN_1 2'h0
`define BDU_LEN_2 2'h1
`define BDU_LEN_4 2'h3
`define BDU_TRAP_VEC 8'h01

// ==========================================================
// interrupt status bits
`define BDU_IRQ_HIT 0
`define BDU_IRQ_GUARD 1
`define BDU_IRQ_STEP 2
`define BDU_IRQ_TASK 3

// ==========================================================
// reset values
`define BDU_WORD_RST 32'h0000_0000

`endif

// [pkg/bdu_pkg.sv]
/*
  types of the breakpoint debug unit: the packed state of the top module.
  assumes bdu_regs.svh supplies all numbers.
*/
`default_nettype none
package bdu_pkg;

  // ==========================================================
  // whole state of the top module
  typedef struct packed {
    logic [3:0][31:0] bp_addr;
    logic [3:0] hit;
    logic bd;
    logic bs;
    logic bt;
    logic [3:0] arm_l;
    logic [3:0] arm_g;
    logic le;
    logic ge;
    logic gd;
    logic [3:0][1:0] kind;
    logic [3:0][1:0] width;
    logic [3:0] irq_sts;
    logic [3:0] irq_mask;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic trap;
    logic [7:0] trap_vec;
    logic irq;
    logic [31:0] dreg_rdata;
    logic dreg_ack;
    logic dreg_blocked;
  } bdu_state_t;

endpackage
`default_nettype wire

// [verilog/bdu_match.sv]
/*
  one breakpoint comparator: execution and data region matching.
  assumes all inputs come from the same clock domain.
*/
`timescale 1ns/10ps
`default_nettype none
`include "bdu_regs.svh"

module bdu_match (
  input wire logic [31:0] bp_addr,
  input wire logic [1:0] width,
  input wire logic [1:0] kind,
  input wire logic fetch_valid,
  input wire logic [31:0] fetch_addr,
  input wire logic data_valid,
  input wire logic [31:0] data_addr,
  input wire logic data_write,
  input wire logic [1:0] data_size,
  output logic match
);

  logic [31:0] msk;
  logic len_ok;
  logic [31:0] bp_lo;
  logic [31:0] bp_hi;
  logic [31:0] acc_hi;
  logic data_kind_ok;

  // ==========================================================
  // region from address and width
  always_comb begin
    len_ok = 1'b1;
    unique case (width)
      `BDU_LEN_1: msk = 32'h0000_0000; // [RULE7]
      `BDU_LEN_2: msk = 32'h0000_0001; // [RULE7]
      `BDU_LEN_4: msk = 32'h0000_0003; // [RULE7]
      default: begin
        // reserved width never matches a data access
        msk = 32'h0000_0000;
        len_ok = 1'b0;
      end
    endcase
    bp_lo = bp_addr & ~msk;
    bp_hi = bp_lo | msk;
    acc_hi = data_addr + {30'h000_0000, data_size};
  end

  // ==========================================================
  // match condition
  always_comb begin
    data_kind_ok = 1'b0;
    match = 1'b0;
    unique case (kind)
      `BDU_KIND_EXEC: begin
        // width ignored for fetches; software keeps it at one byte
        match = fetch_valid && (fetch_addr == bp_addr); // [RULE10]
      end
      `BDU_KIND_WRITE: data_kind_ok = data_write; // [RULE10]
      `BDU_KIND_RW: data_kind_ok = 1'b1; // [RULE10]
      default: data_kind_ok = 1'b0;
    endcase
    // accesses wrapping past the top of memory are not matched
    if (data_valid && data_kind_ok && len_ok &&
        (data_addr <= bp_hi) && (acc_hi >= bp_lo)) begin
      match = 1'b1; // [RULE16]
    end
  end

endmodule // bdu_match
`default_nettype wire

// [test/bdu_top_sva.sv]
/* port checker of the breakpoint debug unit, bound into bdu_top.
   assumes one clock and a synchronous active-low reset. */
`timescale 1ns/10ps
`default_nettype none
`include "bdu_regs.svh"
module bdu_chk (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic fetch_valid,
  input wire logic data_valid,
  input wire logic step_done,
  input wire logic task_switch,
  input wire logic task_trap_bit,
  input wire logic dreg_req,
  input wire logic dreg_ack,
  input wire logic dreg_blocked,
  input wire logic [31:0] dreg_rdata,
  input wire logic debug_trap,
  input wire logic [7:0] trap_vector
);
  logic cause;
  assign cause = fetch_valid | data_valid | step_done | task_switch | dreg_req;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  // ==========
  // assertions
  a_trap_vec: assert property (
    debug_trap |-> trap_vector == `BDU_TRAP_VEC)
    else $error("trap vector wrong");
  a_trap_cause: assert property (
    debug_trap |-> $past(cause))
    else $error("trap without a cause");
  a_step_trap: assert property (
    step_done |=> debug_trap)
    else $error("no trap after single step");
  a_task_trap: assert property (
    task_switch && task_trap_bit |=> debug_trap)
    else $error("no trap on task entry");
  a_guard_block: assert property (
    dreg_blocked |-> dreg_ack && debug_trap && dreg_rdata == 32'h0000_0000)
    else $error("blocked access not trapped");
  a_guard_clear: assert property (
    dreg_blocked && dreg_req |=> dreg_ack && !dreg_blocked)
    else $error("guard not cleared by trap");
  a_dreg_ack: assert property (dreg_req |=> dreg_ack)
    else $error("debug register access not answered");
  a_apb_wait: assert property (psel && penable && !pready |=> pready)
    else $error("apb answer late");
  c_trap: cover property (debug_trap);
  c_guard: cover property (dreg_blocked ##1 dreg_ack);
  c_step: cover property (step_done ##1 debug_trap);
endmodule // bdu_chk

bind bdu_top bdu_chk u_chk (.core_clk, .resetn, .psel, .penable, .pready,
  .fetch_valid, .data_valid, .step_done, .task_switch, .task_trap_bit,
  .dreg_req, .dreg_ack, .dreg_blocked, .dreg_rdata, .debug_trap,
  .trap_vector);
`default_nettype wire

// [test/bdu_core_model.sv]
/* core side model: fetch, load/store, single step, task switch and debug
   register instructions. assumes the bench calls its tasks. */
`timescale 1ns/10ps
`default_nettype none
module bdu_core_model (
  input wire logic core_clk,
  input wire logic dreg_ack,
  input wire logic dreg_blocked,
  input wire logic [31:0] dreg_rdata,
  output var logic fetch_valid,
  output var logic [31:0] fetch_addr,
  output var logic data_valid,
  output var logic [31:0] data_addr,
  output var logic data_write,
  output var logic [1:0] data_size,
  output var logic step_done,
  output var logic task_switch,
  output var logic task_trap_bit,
  output var logic dreg_req,
  output var logic dreg_write,
  output var logic [2:0] dreg_idx,
  output var logic [31:0] dreg_wdata
);
  initial begin
    {fetch_valid, data_valid, step_done, task_switch, dreg_req} = '0;
    {fetch_addr, data_addr, data_write, data_size, task_trap_bit} = '0;
    {dreg_write, dreg_idx, dreg_wdata} = '0;
  end
  // ==========
  // k: task switch, step, data, fetch; w is also the trap-on-entry bit
  task automatic go(input logic [3:0] k, input logic [31:0] a,
    input logic w, input logic [1:0] sz);
    @(posedge core_clk);
    {task_switch, step_done, data_valid, fetch_valid} <= k;
    fetch_addr <= a;
    data_addr <= a;
    data_write <= w;
    data_size <= sz;
    task_trap_bit <= w;
    @(posedge core_clk);
    {task_switch, step_done, data_valid, fetch_valid} <= 4'h0;
    // stale addresses flip so they cannot match by accident
    fetch_addr <= ~a;
    data_addr <= ~a;
  endtask
  // n back-to-back requests; returns the answer to the last one
  task automatic dreg(input logic w, input logic [2:0] i,
    input logic [31:0] d, input int n, output logic [31:0] rd,
    output logic blk);
    rd = 'x;
    blk = 1'bx;
    @(posedge core_clk);
    dreg_req <= 1'b1;
    dreg_write <= w;
    dreg_idx <= i;
    dreg_wdata <= d;
    repeat (n) @(posedge core_clk);
    dreg_req <= 1'b0;
    dreg_wdata <= ~d;
    for (int k = 0; k < 4; k++) begin
      @(posedge core_clk);
      if (dreg_ack === 1'b1) begin
        rd = dreg_rdata;
        blk = dreg_blocked;
        break;
      end
    end
  endtask
endmodule // bdu_core_model
`default_nettype wire

// [test/tb_top.sv]
/* self-checking bench of bdu_top: apb master, core model, random
   breakpoints. assumes the checker is bound in by its own file. */
`timescale 1ns/10ps
`default_nettype none
`include "bdu_regs.svh"
module tb_top;
  logic core_clk, resetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0] paddr, trap_vector;
  logic [31:0] pwdata, prdata, dreg_rdata, fetch_addr, data_addr, dreg_wdata;
  logic fetch_valid, data_valid, data_write, step_done, task_switch;
  logic task_trap_bit, dreg_req, dreg_write, dreg_ack, dreg_blocked;
  logic debug_trap, e, h;
  logic [1:0] data_size, kd, wd, m, arm, lg;
  logic [2:0] dreg_idx;
  logic [31:0] r;
  logic [31:0] bp [4];
  int err_count = 0;
  int checked = 0;
  int traps = 0;
  int t0, ty;
  bdu_top u_dut (.core_clk, .resetn, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .fetch_valid, .fetch_addr,
    .data_valid, .data_addr, .data_write, .data_size, .step_done,
    .task_switch, .task_trap_bit, .dreg_req, .dreg_write, .dreg_idx,
    .dreg_wdata, .dreg_rdata, .dreg_ack, .dreg_blocked, .debug_trap,
    .trap_vector, .irq);
  bdu_core_model u_core (.core_clk, .dreg_ack, .dreg_blocked, .dreg_rdata,
    .fetch_valid, .fetch_addr, .data_valid, .data_addr, .data_write,
    .data_size, .step_done, .task_switch, .task_trap_bit, .dreg_req,
    .dreg_write, .dreg_idx, .dreg_wdata);
  // ==========
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    if (err_count == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    for (int k = 0; k < 9; k++) begin
      @(posedge core_clk);
      if (pready === 1'b1) begin
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        return;
      end
    end
    err_count++;
    stop_test();
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0000_0000);
    chk(r, x);
  endtask
  // t: 0 fetch, 1 data read, 2 data write
  function automatic logic hit(logic [1:0] k, logic [1:0] w, int t);
    if (t == 0) return k == 2'h0;
    return w != 2'h2 && (k == 2'h3 || k == 2'h1 && t == 2);
  endfunction
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (debug_trap === 1'b1) traps <= traps + 1;
  initial begin
    repeat (100000) @(posedge core_clk);
    err_count++;
    stop_test();
  end
  // ==========
  // main sequence
  initial begin
    void'($urandom(32'hacdc));
    {psel, penable, pwrite, paddr, pwdata, resetn} = '0;
    repeat (20) @(posedge core_clk);
    resetn <= 1'b1;
    for (int a = 0; a < 36; a += 4) begin
      rd(8'(a), 32'h0000_0000);
      chk(e, a == 32);
    end
    chk(trap_vector, `BDU_TRAP_VEC);
    for (int i = 0; i < 4; i++) begin
      bp[i] = $urandom & 32'hffff_fff0 | 32'h0000_0100;
      apb(1'b1, 8'(4 * i), bp[i]);
      rd(8'(4 * i), bp[i]);
    end
    for (int n = 0; n < 48; n++) begin
      kd = n[1:0];
      wd = n[3:2];
      ty = n / 16;
      if (ty == 0 && wd != 2'h0) continue;
      arm = 2'($urandom);
      lg = 2'($urandom);
      m = wd == 2'h3 ? 2'h3 : {1'b0, wd[0]};
      h = hit(kd, wd, ty);
      apb(1'b1, `BDU_ADDR_CTRL, {12'h0, wd, kd, 6'h0, lg, 6'h0, arm});
      t0 = traps;
      u_core.go(ty == 0 ? 4'h1 : 4'h2, ty == 2 ? bp[0] - 1 : bp[0] | m,
        ty == 2, ty == 2 ? 2'h1 : 2'h0);
      u_core.go(4'h2, bp[0] + 4, 1'b1, 2'h0);
      rd(`BDU_ADDR_STATUS, {31'h0, h});
      chk(traps - t0, {31'h0, h && arm != 2'h0});
      apb(1'b1, `BDU_ADDR_STATUS, 32'h0000_0000);
    end
    apb(1'b1, `BDU_ADDR_BP1, bp[0]);
    apb(1'b1, `BDU_ADDR_CTRL, 32'h00ff_0009);
    t0 = traps;
    u_core.go(4'h2, bp[0] + 2, 1'b0, 2'h0);
    rd(`BDU_ADDR_STATUS, 32'h0000_0003);
    chk(traps - t0, 32'h0000_0001);
    apb(1'b1, `BDU_ADDR_STATUS, 32'h0000_0000);
    apb(1'b1, `BDU_ADDR_CTRL, 32'h0000_00ff);
    t0 = traps;
    u_core.go(4'h8, 32'h0000_0000, 1'b0, 2'h0);
    u_core.go(4'h8, 32'h0000_0000, 1'b1, 2'h0);
    rd(`BDU_ADDR_CTRL, 32'h0000_00aa);
    rd(`BDU_ADDR_STATUS, 32'h0000_8000);
    chk(traps - t0, 32'h0000_0001);
    apb(1'b0, `BDU_ADDR_IRQ_STS, 32'h0000_0000);
    apb(1'b1, `BDU_ADDR_IRQ_MASK, 32'h0000_0000);
    u_core.go(4'h4, 32'h0000_0000, 1'b0, 2'h0);
    rd(`BDU_ADDR_STATUS, 32'h0000_c000);
    chk(irq, 32'h0000_0000);
    apb(1'b1, `BDU_ADDR_IRQ_MASK, 32'h0000_000f);
    repeat (2) @(posedge core_clk);
    chk(irq, 32'h0000_0001);
    rd(`BDU_ADDR_IRQ_STS, 32'h0000_0004);
    repeat (2) @(posedge core_clk);
    chk(irq, 32'h0000_0000);
    apb(1'b1, `BDU_ADDR_STATUS, 32'h0000_0000);
    apb(1'b1, `BDU_ADDR_STATUS, 32'hffff_ffff);
    rd(`BDU_ADDR_STATUS, 32'h0000_0000);
    apb(1'b1, `BDU_ADDR_CTRL, 32'h0000_2000);
    u_core.dreg(1'b0, `BDU_IDX_STATUS, 32'h0000_0000, 2, r, e);
    chk(r, 32'h0000_2000);
    chk(e, 32'h0000_0000);
    rd(`BDU_ADDR_CTRL, 32'h0000_0000);
    apb(1'b1, `BDU_ADDR_CTRL, 32'h0000_2000);
    u_core.dreg(1'b1, 3'h3, ~bp[3], 1, r, e);
    chk(e, 32'h0000_0001);
    rd(`BDU_ADDR_BP3, bp[3]);
    u_core.dreg(1'b1, 3'h3, ~bp[3], 1, r, e);
    chk(e, 32'h0000_0000);
    rd(`BDU_ADDR_BP3, ~bp[3]);
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
